//--- src/hwm_limit_status_one.v
// hardware-monitor interrupt status register 1 with an axi4-lite slave
`timescale 1ns/1ns
`include "hwm_limit_status_one_consts.vh"

module hwm_limit_status_one #(
  parameter WIDTH = 8,
  parameter CHANNELS = 7
) (
  input wire sys_clk,
  input wire rst_n,
  // axi4-lite write address
  input wire [11:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // axi4-lite write response
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read address
  input wire [11:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // axi4-lite read data
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  // monitor side, same clock
  input wire [CHANNELS*WIDTH-1:0] reading_bus,
  input wire [CHANNELS*WIDTH-1:0] low_limit_bus,
  input wire [CHANNELS*WIDTH-1:0] high_limit_bus,
  input wire [1:0] diode_fault,
  input wire second_status_summary,
  // pin from the power supply, asynchronous
  input wire power_good_input,
  output wire monitor_run
);

  // ------------------------------------------------------------
  // address map
  // ------------------------------------------------------------
  localparam [7:0] IDX_CONFIG = `HWM_IDX_CONFIG;
  localparam [7:0] IDX_STATUS = `HWM_IDX_STATUS_ONE;
  localparam [7:0] IDX_VOLT = `HWM_IDX_VOLT_ENABLE;
  localparam [7:0] IDX_TEMP = `HWM_IDX_TEMP_ENABLE;
  localparam [11:0] ADDR_CONFIG = {2'h0, IDX_CONFIG, 2'h0};
  localparam [11:0] ADDR_STATUS = {2'h0, IDX_STATUS, 2'h0};
  localparam [11:0] ADDR_VOLT = {2'h0, IDX_VOLT, 2'h0};
  localparam [11:0] ADDR_TEMP = {2'h0, IDX_TEMP, 2'h0};

  // ------------------------------------------------------------
  // status reset value, split into flags and summary
  // ------------------------------------------------------------
  localparam [7:0] STATUS_RESET = `HWM_STATUS_ONE_RESET;
  localparam [CHANNELS-1:0] FLAG_RESET = STATUS_RESET[CHANNELS-1:0];
  localparam [0:0] SUMMARY_RESET = STATUS_RESET[`HWM_SUMMARY_BIT];

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  reg awready_reg;
  reg wready_reg;
  reg bvalid_reg;
  reg [1:0] bresp_reg;
  reg [11:0] awaddr_reg;
  reg [31:0] wdata_reg;
  reg [3:0] wstrb_reg;
  reg arready_reg;
  reg rvalid_reg;
  reg [1:0] rresp_reg;
  reg [31:0] rdata_reg;

  reg [7:0] config_reg;
  reg [7:0] volt_enable_reg;
  reg [7:0] temp_enable_reg;
  reg [CHANNELS-1:0] flag_reg;
  reg [CHANNELS-1:0] flag_next;
  reg summary_reg;

  reg pg_meta_reg;
  reg pg_sync_reg;
  reg pg_prev_reg;

  wire [CHANNELS-1:0] violation;
  wire [CHANNELS-1:0] enable_vec;
  wire run;
  wire pg_rise;
  wire wr_fire;
  wire wr_low_lane;
  wire wr_hit_config;
  wire wr_hit_status;
  wire wr_hit_volt;
  wire wr_hit_temp;
  wire wr_mapped;
  wire [CHANNELS-1:0] clear_request;
  wire [CHANNELS-1:0] live_clear;
  wire [7:0] status_value;
  wire ar_fire;
  reg [31:0] rd_value;
  reg rd_mapped;

  // ------------------------------------------------------------
  // limit comparison
  // ------------------------------------------------------------
  assign run = config_reg[`HWM_RUN_BIT];

  hwm_limit_compare #(
    .CHANNELS(CHANNELS),
    .WIDTH(WIDTH)
  ) u_compare (
    .reading_bus(reading_bus),
    .low_limit_bus(low_limit_bus),
    .high_limit_bus(high_limit_bus),
    .diode_fault(diode_fault),
    .run(run),
    .violation(violation)
  );

  // ------------------------------------------------------------
  // power-good synchroniser and rising edge
  // ------------------------------------------------------------
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pg_meta_reg <= 1'b0;
      pg_sync_reg <= 1'b0;
      pg_prev_reg <= 1'b0;
    end else begin
      pg_meta_reg <= power_good_input;
      pg_sync_reg <= pg_meta_reg;
      pg_prev_reg <= pg_sync_reg;
    end
  end

  assign pg_rise = pg_sync_reg & ~pg_prev_reg;

  // ------------------------------------------------------------
  // write channels: address and data in either order
  // ------------------------------------------------------------
  assign wr_fire = ~awready_reg & ~wready_reg & ~bvalid_reg;
  assign wr_low_lane = wr_fire & wstrb_reg[0];
  assign wr_hit_config = awaddr_reg == ADDR_CONFIG;
  assign wr_hit_status = awaddr_reg == ADDR_STATUS;
  assign wr_hit_volt = awaddr_reg == ADDR_VOLT;
  assign wr_hit_temp = awaddr_reg == ADDR_TEMP;
  assign wr_mapped = wr_hit_config | wr_hit_status | wr_hit_volt | wr_hit_temp;

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      bvalid_reg <= 1'b0;
      bresp_reg <= `HWM_RESP_OKAY;
      awaddr_reg <= 12'h000;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
    end else begin
      if (s_axi_awvalid && awready_reg) begin
        awready_reg <= 1'b0;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_reg) begin
        wready_reg <= 1'b0;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_mapped ? `HWM_RESP_OKAY : `HWM_RESP_SLVERR;
      end
      if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // software-written registers
  // ------------------------------------------------------------
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      config_reg <= `HWM_CONFIG_RESET;
      volt_enable_reg <= `HWM_VOLT_ENABLE_RESET;
      temp_enable_reg <= `HWM_TEMP_ENABLE_RESET;
    end else if (wr_low_lane) begin
      if (wr_hit_config) begin
        config_reg <= wdata_reg[7:0];
      end
      if (wr_hit_volt) begin
        volt_enable_reg <= wdata_reg[7:0];
      end
      if (wr_hit_temp) begin
        temp_enable_reg <= wdata_reg[7:0];
      end
    end
  end

  // group and global enables are stored only, never gate the flags
  assign enable_vec = {temp_enable_reg[`HWM_TEMP_EN_HI:`HWM_TEMP_EN_LO],
                       volt_enable_reg[`HWM_VOLT_HI:`HWM_VOLT_LO]};

  // ------------------------------------------------------------
  // status flags
  // ------------------------------------------------------------
  // write-one clear on status bits 6..0 only; bit 7 has no store
  assign clear_request = (wr_low_lane && wr_hit_status) ?
                         wdata_reg[CHANNELS-1:0] : {CHANNELS{1'b0}};
  assign live_clear = clear_request & ~violation;
  assign status_value = {summary_reg, flag_reg};

  always @* begin
    flag_next = flag_reg;
    if (pg_rise) begin
      flag_next = FLAG_RESET;
    end else if (run) begin
      // clear only where the event has ended, so a live event wins
      flag_next = flag_reg & ~live_clear;
      flag_next = flag_next | violation;
      // disabled flags drop at once, and when run comes back
      flag_next = flag_next & enable_vec;
    end
    // run low: flags hold whatever the enables do
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_reg <= FLAG_RESET;
    end else begin
      flag_reg <= flag_next;
    end
  end

  // ------------------------------------------------------------
  // summary of the second status register
  // ------------------------------------------------------------
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      summary_reg <= SUMMARY_RESET;
    end else begin
      summary_reg <= pg_rise ? SUMMARY_RESET : second_status_summary;
    end
  end

  // ------------------------------------------------------------
  // read channel
  // ------------------------------------------------------------
  assign ar_fire = s_axi_arvalid & arready_reg;

  always @* begin
    rd_value = 32'h00000000;
    rd_mapped = 1'b1;
    case (s_axi_araddr)
      ADDR_CONFIG: begin
        rd_value[7:0] = config_reg;
      end
      ADDR_STATUS: begin
        rd_value[7:0] = status_value;
      end
      ADDR_VOLT: begin
        rd_value[7:0] = volt_enable_reg;
      end
      ADDR_TEMP: begin
        rd_value[7:0] = temp_enable_reg;
      end
      default: begin
        rd_mapped = 1'b0;
      end
    endcase
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rresp_reg <= `HWM_RESP_OKAY;
      rdata_reg <= 32'h00000000;
    end else begin
      if (ar_fire) begin
        arready_reg <= 1'b0;
        rvalid_reg <= 1'b1;
        rdata_reg <= rd_value;
        rresp_reg <= rd_mapped ? `HWM_RESP_OKAY : `HWM_RESP_SLVERR;
      end
      if (rvalid_reg && s_axi_rready) begin
        rvalid_reg <= 1'b0;
        arready_reg <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;
  assign monitor_run = config_reg[`HWM_RUN_BIT];

endmodule // hwm_limit_status_one

//--- src/hwm_limit_status_one_consts.vh
// constants for the hardware-monitor limit status block
// Summary of operation
// - 8-bit status register at index 41h, cleared to 00h on power-good rising edge.
// - bit 7 reads one while any second-status flag is set, else zero.
// - bit 7 is read-only; writing one there changes nothing.
// - bits 0-3 set when voltage reading is at/below low or above high limit.
// - bits 4-6 set when temperature reading is at/below low or above high limit.
// - bits 0-6 stay set until written one or their enable is cleared.
// - writing one clears a temperature flag only when its event has ended.
// - writing one clears a voltage flag only when its reading is back in limits.
// - no flag sets unless run bit and its own enable are both one.
// - with run one, clearing a set flag's enable clears the flag at once.
// - with run zero, clearing an enable leaves the flag until run returns.
// - setting run clears flags with enable zero; enabled flags unaffected by run.
// - diode and internal-sensor enables live in temperature enable register 82h.
// - group temperature and global interrupt enables never change the flags.
// - with run zero nothing is monitored and no flags set.
// - diode fault with run set forces reading to 80h, raising its limit flag.
`ifndef HWM_LIMIT_STATUS_ONE_CONSTS_VH
`define HWM_LIMIT_STATUS_ONE_CONSTS_VH

// register indices; byte address is four times the index
`define HWM_IDX_CONFIG 8'h40
`define HWM_IDX_STATUS_ONE 8'h41
`define HWM_IDX_VOLT_ENABLE 8'h81
`define HWM_IDX_TEMP_ENABLE 8'h82

// reset values
`define HWM_STATUS_ONE_RESET 8'h00
`define HWM_CONFIG_RESET 8'h00
`define HWM_VOLT_ENABLE_RESET 8'h00
`define HWM_TEMP_ENABLE_RESET 8'h00

// status register fields
`define HWM_SUMMARY_BIT 7
`define HWM_FLAG_COUNT 7
`define HWM_VOLT_LO 0
`define HWM_VOLT_HI 3
`define HWM_DIODE_ONE_CH 4
`define HWM_DIODE_TWO_CH 6

// config register fields
`define HWM_RUN_BIT 0

// voltage enable register fields
`define HWM_GLOBAL_IRQ_BIT 7

// temperature enable register fields
`define HWM_GROUP_TEMP_BIT 0
`define HWM_TEMP_EN_LO 1
`define HWM_TEMP_EN_HI 3

// reading forced on a remote diode fault
`define HWM_DIODE_FAULT_READING 8'h80

// bus answers
`define HWM_RESP_OKAY 2'h0
`define HWM_RESP_SLVERR 2'h2

`endif

//--- src/hwm_limit_compare.v
// per-channel window comparison of monitor readings against limits
`timescale 1ns/1ns
`include "hwm_limit_status_one_consts.vh"

module hwm_limit_compare #(
  parameter CHANNELS = 7,
  parameter WIDTH = 8
) (
  input wire [CHANNELS*WIDTH-1:0] reading_bus,
  input wire [CHANNELS*WIDTH-1:0] low_limit_bus,
  input wire [CHANNELS*WIDTH-1:0] high_limit_bus,
  input wire [1:0] diode_fault,
  input wire run,
  output wire [CHANNELS-1:0] violation
);

  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch = ch + 1) begin : g_ch
      wire [WIDTH-1:0] raw;
      wire [WIDTH-1:0] low;
      wire [WIDTH-1:0] high;
      wire forced;
      wire [WIDTH-1:0] value;
      assign raw = reading_bus[ch*WIDTH +: WIDTH];
      assign low = low_limit_bus[ch*WIDTH +: WIDTH];
      assign high = high_limit_bus[ch*WIDTH +: WIDTH];
      // faulted diode channel reads the fixed fault value while run is set
      if (ch == `HWM_DIODE_ONE_CH) begin : g_d1
        assign forced = run & diode_fault[0];
      end else if (ch == `HWM_DIODE_TWO_CH) begin : g_d2
        assign forced = run & diode_fault[1];
      end else begin : g_none
        assign forced = 1'b0;
      end
      assign value = forced ? `HWM_DIODE_FAULT_READING : raw;
      assign violation[ch] = (value <= low) | (value > high);
    end
  endgenerate

endmodule // hwm_limit_compare

//--- verif/hwm_limit_status_one_chk.sv
// assertion checker for the limit status block
`timescale 1ns/1ns
module hwm_limit_status_one_chk (
  input logic sys_clk,
  input logic rst_n,
  input logic s_axi_awvalid,
  input logic s_axi_awready,
  input logic s_axi_wvalid,
  input logic s_axi_wready,
  input logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic s_axi_rvalid,
  input logic s_axi_rready,
  input logic [31:0] s_axi_rdata,
  input logic [1:0] s_axi_rresp,
  input logic monitor_run
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  // ----
  // bus timing
  // ----
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
  wr_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  b_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
    else $error("write answer not retired");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read data not held");
  r_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read answer not retired");
  // ----
  // register content
  // ----
  rd_width_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  rd_resp_a: assert property (s_axi_rvalid |-> s_axi_rresp == 2'h0 || s_axi_rresp == 2'h2)
    else $error("bad read response");
  run_src_a: assert property ($changed(monitor_run) |-> $rose(s_axi_bvalid))
    else $error("run bit moved without a write");
  cover property (s_axi_bvalid && s_axi_bready);
  cover property ($rose(monitor_run));
  cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule // hwm_limit_status_one_chk

bind hwm_limit_status_one hwm_limit_status_one_chk hwm_limit_status_one_chk_inst (
  .sys_clk, .rst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .monitor_run);

//--- verif/hwm_limit_status_one_tb_top.sv
// self-checking bench for the limit status block
`timescale 1ns/1ns
module hwm_limit_status_one_tb_top;
  localparam logic [11:0] CFG = 12'h100, ST = 12'h104, VE = 12'h204, TE = 12'h208;
  logic sys_clk = 1'b0, rst_n = 1'b0;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, monitor_run;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [55:0] reading_bus = {7{8'h60}};
  logic [55:0] low_limit_bus = {7{8'h40}}, high_limit_bus = {7{8'h7f}};
  logic [1:0] diode_fault = 2'h0;
  logic second_status_summary = 1'b0, power_good_input = 1'b0;
  logic [33:0] q[$];
  logic [7:0] ex, v;
  int n_errors = 0, n_checks = 0;

  initial forever #25 sys_clk = ~sys_clk;

  hwm_limit_status_one hwm_limit_status_one_inst (
    .sys_clk, .rst_n, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .reading_bus,
    .low_limit_bus, .high_limit_bus, .diode_fault, .second_status_summary,
    .power_good_input, .monitor_run);

  // ----
  // checking and bus tasks
  // ----
  task report_and_stop;
    if (n_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task cmp(input logic [33:0] s);
    logic [33:0] e;
    e = q.pop_front();
    n_checks++;
    if (e !== s) begin
      n_errors++;
      $display("MISMATCH bus_answer exp %h got %h", e, s);
    end
  endtask

  always @(posedge sys_clk) begin
    if ((s_axi_bvalid & s_axi_bready) === 1'b1) cmp({s_axi_bresp, 32'h0});
    if ((s_axi_rvalid & s_axi_rready) === 1'b1) cmp({s_axi_rresp, s_axi_rdata});
  end

  task bus(input logic wr, input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
    logic aw, w, b, ar, rr;
    int n;
    aw = wr;
    w = wr;
    b = wr;
    ar = !wr;
    rr = !wr;
    n = 0;
    @(posedge sys_clk);
    q.push_back({r, wr ? 32'h0 : {24'h0, d}});
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= wr;
    s_axi_wvalid <= wr;
    s_axi_bready <= wr;
    s_axi_arvalid <= !wr;
    s_axi_rready <= !wr;
    while (aw | w | b | ar | rr) begin
      @(posedge sys_clk);
      if (aw & s_axi_awready) begin
        aw = 0;
        s_axi_awvalid <= 1'b0;
      end
      if (w & s_axi_wready) begin
        w = 0;
        s_axi_wvalid <= 1'b0;
      end
      if (b & s_axi_bvalid) begin
        b = 0;
        s_axi_bready <= 1'b0;
      end
      if (ar & s_axi_arready) begin
        ar = 0;
        s_axi_arvalid <= 1'b0;
      end
      if (rr & s_axi_rvalid) begin
        rr = 0;
        s_axi_rready <= 1'b0;
      end
      if (++n > 100) begin
        n_errors++;
        report_and_stop;
      end
    end
  endtask

  task wr(input logic [11:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 2'h0);
  endtask

  task rd(input logic [11:0] a, input logic [7:0] d);
    bus(1'b0, a, d, 2'h0);
  endtask

  task settle;
    repeat (3) @(posedge sys_clk);
  endtask

  // ----
  // main sequence
  // ----
  initial begin
    void'($urandom(50));
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rd(ST, 8'h00);
    rd(CFG, 8'h00);
    bus(1'b0, 12'h300, 8'h00, 2'h2);
    bus(1'b1, 12'h300, 8'h5a, 2'h2);
    reading_bus[7:0] <= 8'h40;
    settle;
    rd(ST, 8'h00);
    wr(VE, 8'h0f);
    wr(TE, 8'h0e);
    rd(ST, 8'h00);
    wr(CFG, 8'h01);
    reading_bus <= 56'h60_00_ff_41_80_7f_40;
    settle;
    rd(ST, 8'h35);
    ex = 8'h35;
    repeat (4) begin
      for (int c = 0; c < 7; c++) begin
        v = 8'($urandom_range(255, 0));
        reading_bus[c*8 +: 8] <= v;
        if (v <= 8'h40 || v > 8'h7f) ex[c] = 1'b1;
      end
      settle;
    end
    rd(ST, ex);
    reading_bus <= 56'h30_60_60_60_20_60_60;
    second_status_summary <= 1'b1;
    settle;
    wr(ST, 8'hff);
    rd(ST, 8'hc4);
    reading_bus[23:16] <= 8'h60;
    second_status_summary <= 1'b0;
    settle;
    wr(ST, 8'h84);
    rd(ST, 8'h40);
    wr(TE, 8'h06);
    rd(ST, 8'h00);
    reading_bus <= 56'h30_60_60_60_60_ff_00;
    settle;
    reading_bus[15:8] <= 8'h60;
    settle;
    wr(CFG, 8'h00);
    wr(VE, 8'h0e);
    rd(ST, 8'h03);
    wr(CFG, 8'h01);
    rd(ST, 8'h02);
    wr(VE, 8'h8e);
    wr(VE, 8'h0e);
    wr(TE, 8'h07);
    wr(TE, 8'h06);
    rd(ST, 8'h02);
    rd(VE, 8'h0e);
    rd(TE, 8'h06);
    reading_bus[55:48] <= 8'h60;
    wr(TE, 8'h0e);
    diode_fault <= 2'h1;
    settle;
    rd(ST, 8'h12);
    diode_fault <= 2'h0;
    settle;
    wr(ST, 8'h10);
    rd(ST, 8'h02);
    power_good_input <= 1'b1;
    repeat (6) @(posedge sys_clk);
    rd(ST, 8'h00);
    report_and_stop;
  end
endmodule // hwm_limit_status_one_tb_top
